// file: design/ipc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "ipc_defines.svh"
// Notes on behaviour
// - Second fast vector high holds 5 bits, joined with low half into 21-bit address.
// - Pending bits read 0 while request outstanding, 1 otherwise, ascending order.
// - First pending register shows vectors 2 to 16; lowest bit reads one.
// - Second pending register shows vectors 17 to 32.
// - Third pending register is read-only, vectors 33 to 48, resets all ones.
// - Fourth pending register shows vectors 49 to 63.
// - Control top bit shows whether an interrupt is driven to the core.
// - Two-bit nest level gives the level a request must exceed to preempt.
// - Nest level changes only when the core enters a new service routine, or clears to zero when the core signals exit.
// - Seven-bit field captures vector address bits 7 to 1 of the last entry.
// - A nested entry may overwrite captured fields before software reads them.
// - Global block bit 5 stops all interrupts; resets to zero.
// - Reset vector shown during reset until second rising edge after release.
// - Reset returns all registers to defaults, programmable requests disabled.
// - Vector base gives upper 14 bits, request number times two the lower 7.
// - Fast vector is used when a level-2 request wins and the fast request is pending at level 2; fast 0 beats fast 1.
module ipc_ctrl
    import ipc_pkg::*;
(
    input  wire logic         core_clk_in,
    input  wire logic         nrst_in,
    input  wire logic [4:0]   avs_address_in,
    input  wire logic         avs_read_in,
    input  wire logic         avs_write_in,
    input  wire logic [31:0]  avs_writedata_in,
    input  wire logic [3:0]   avs_byteenable_in,
    output logic      [31:0]  avs_readdata_out,
    output logic              avs_waitrequest_out,
    input  wire logic [63:2]  irq_req_in,
    input  wire logic [127:0] irq_level_in,
    input  wire logic         core_ack_in,
    input  wire logic         core_exit_in,
    output logic              core_irq_out,
    output logic      [1:0]   required_nest_level_out,
    output logic      [20:0]  vector_address_bus_out
);

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [15:0] msk);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]} & msk;
endfunction

// Highest code wins; among equals the lowest vector number
function automatic logic [7:0] pick(input logic [63:2] pend, input logic [127:0] lvl);
    logic [1:0] best;
    logic [5:0] vec;
    best = 2'h0;
    vec  = 6'h00;
    for (int i = 63; i >= 2; i--) begin
        if (pend[i] && lvl[2*i +: 2] != 2'h0 && lvl[2*i +: 2] >= best) begin
            best = lvl[2*i +: 2];
            vec  = i[5:0];
        end
    end
    pick = {best, vec};
endfunction

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
logic [15:0] vbase_q, fm0_q, fvl0_q, fvh0_q, fm1_q, fvl1_q, fvh1_q;
logic [63:2] pend_q;
logic        dis_q;
ipc_code_t   required_nest_level_q;
logic [6:0]  vabf_q;
logic        irq_q;
logic [20:0] vab_q;
ipc_code_t   wcode_q;
ipc_hold_t   hold_q;
logic        wait_q;
logic [31:0] rdata_q;

// ----------------------------------------------------------------
// Arbitration
// ----------------------------------------------------------------
wire [7:0]  win    = pick(pend_q, irq_level_in);
wire [1:0]  wcode  = win[7:6];
// Padded so that a match value of 0 or 1 never selects outside the pending range
wire [63:0] pend_all = {pend_q, 2'b00};
wire        f0_hit = pend_all[fm0_q[5:0]] && fm0_q[5:0] >= 6'h02 && irq_level_in[2*fm0_q[5:0] +: 2] == 2'h3;
wire        f1_hit = pend_all[fm1_q[5:0]] && fm1_q[5:0] >= 6'h02 && irq_level_in[2*fm1_q[5:0] +: 2] == 2'h3;
wire [20:0] norm_a = {vbase_q[13:0], win[5:0], 1'b0};
wire [20:0] f0_a   = {fvh0_q[4:0], fvl0_q};
wire [20:0] f1_a   = {fvh1_q[4:0], fvl1_q};
wire [20:0] vab_d  = (wcode == 2'h3 && f0_hit) ? f0_a :
                     (wcode == 2'h3 && f1_hit) ? f1_a : norm_a;
// Admit when winner level exceeds the threshold held in the nest level
wire        irq_d  = (hold_q == IPC_RUN) && wcode > required_nest_level_q && !dis_q;
// Reset vector is the vector base reset value in the upper 14 bits
localparam logic [15:0] rst_base = `IPC_RST_VBASE;
localparam logic [20:0] rst_a    = {rst_base[13:0], 7'h00};

// ----------------------------------------------------------------
// Register bus decode
// ----------------------------------------------------------------
wire        req    = (avs_read_in | avs_write_in) & wait_q;
wire        wr     = avs_write_in & ~wait_q;
wire [4:0]  a      = avs_address_in;
wire [3:0]  be     = avs_byteenable_in;
wire [31:0] wd     = avs_writedata_in;
wire [15:0] ctrl_r = {irq_q, required_nest_level_q, vabf_q, dis_q, `IPC_CTRL_FIXED};
wire [15:0] rd_mux =
    (a == `IPC_IDX_VBASE) ? vbase_q :
    (a == `IPC_IDX_FM0)   ? fm0_q :
    (a == `IPC_IDX_FVL0)  ? fvl0_q :
    (a == `IPC_IDX_FVH0)  ? fvh0_q :
    (a == `IPC_IDX_FM1)   ? fm1_q :
    (a == `IPC_IDX_FVL1)  ? fvl1_q :
    (a == `IPC_IDX_FVH1)  ? fvh1_q :
    (a == `IPC_IDX_PEND0) ? {~pend_q[16:2], `IPC_PEND0_RSVD} :
    (a == `IPC_IDX_PEND1) ? ~pend_q[32:17] :
    (a == `IPC_IDX_PEND2) ? ~pend_q[48:33] :
    (a == `IPC_IDX_PEND3) ? {1'b1, ~pend_q[63:49]} :
    (a == `IPC_IDX_CTRL)  ? ctrl_r : 16'h0000;

// ----------------------------------------------------------------
// Bus slave: one wait cycle, then answer for one cycle
// ----------------------------------------------------------------
always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        wait_q  <= 1'b1;
        rdata_q <= 32'h0000_0000;
    end else begin
        wait_q  <= ~req;
        rdata_q <= req ? {16'h0000, rd_mux} : rdata_q;
    end
end

// Pure-read pending bits ignore writes
always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        vbase_q <= `IPC_RST_VBASE;
        fm0_q   <= `IPC_RST_ZERO;
        fvl0_q  <= `IPC_RST_ZERO;
        fvh0_q  <= `IPC_RST_ZERO;
        fm1_q   <= `IPC_RST_ZERO;
        fvl1_q  <= `IPC_RST_ZERO;
        fvh1_q  <= `IPC_RST_ZERO;
        dis_q   <= 1'(`IPC_RST_CTRL >> `IPC_CTRL_DIS);
    end else if (wr) begin
        if (a == `IPC_IDX_VBASE) vbase_q <= merge16(vbase_q, wd, be, `IPC_MSK_VBASE);
        if (a == `IPC_IDX_FM0)   fm0_q   <= merge16(fm0_q, wd, be, `IPC_MSK_FM);
        if (a == `IPC_IDX_FVL0)  fvl0_q  <= merge16(fvl0_q, wd, be, `IPC_MSK_FVL);
        if (a == `IPC_IDX_FVH0)  fvh0_q  <= merge16(fvh0_q, wd, be, `IPC_MSK_FVH);
        if (a == `IPC_IDX_FM1)   fm1_q   <= merge16(fm1_q, wd, be, `IPC_MSK_FM);
        if (a == `IPC_IDX_FVL1)  fvl1_q  <= merge16(fvl1_q, wd, be, `IPC_MSK_FVL);
        if (a == `IPC_IDX_FVH1)  fvh1_q  <= merge16(fvh1_q, wd, be, `IPC_MSK_FVH);
        if (a == `IPC_IDX_CTRL && be[0]) dis_q <= wd[`IPC_CTRL_DIS];
    end
end

// ----------------------------------------------------------------
// Pending capture and core handshake
// ----------------------------------------------------------------
always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        pend_q <= 62'h0;
        hold_q <= IPC_HOLD0;
    end else begin
        pend_q <= irq_req_in;
        case (hold_q)
            IPC_HOLD0: hold_q <= IPC_HOLD1;
            IPC_HOLD1: hold_q <= IPC_RUN;
            IPC_RUN:   hold_q <= IPC_RUN;
            default:   hold_q <= IPC_RUN;
        endcase
    end
end

// Vector stays at the reset address through the first edge after release
always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        vab_q   <= rst_a;
        irq_q   <= 1'b0;
        wcode_q <= 2'h0;
    end else begin
        vab_q   <= (hold_q == IPC_HOLD0) ? rst_a : vab_d;
        irq_q   <= irq_d;
        wcode_q <= wcode;
    end
end

// Fields reflect whatever the core took last; a nested entry overwrites them
always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        required_nest_level_q <= 2'h0;
        vabf_q <= 7'h00;
    end else if (core_ack_in && irq_q) begin
        required_nest_level_q <= wcode_q;
        vabf_q <= vab_q[7:1];
    end else if (core_exit_in) begin
        required_nest_level_q <= 2'h0;
    end
end

assign avs_readdata_out        = rdata_q;
assign avs_waitrequest_out     = wait_q;
assign core_irq_out            = irq_q;
assign required_nest_level_out = required_nest_level_q;
assign vector_address_bus_out  = vab_q;

// ----------------------------------------------------------------
// Checks
// ----------------------------------------------------------------
property p_irq_block;
    @(posedge core_clk_in) disable iff (!nrst_in) dis_q |=> !irq_q;
endproperty
a_irq_block: assert property (p_irq_block) else $error("core request while blocked");

property p_nest_hold;
    @(posedge core_clk_in) disable iff (!nrst_in)
        !(core_ack_in && irq_q) && !core_exit_in |=> $stable(required_nest_level_q);
endproperty
a_nest_hold: assert property (p_nest_hold) else $error("nest level moved without entry");

property p_nest_take;
    @(posedge core_clk_in) disable iff (!nrst_in)
        core_ack_in && irq_q |=> required_nest_level_q == $past(wcode_q) && required_nest_level_q != 2'h0;
endproperty
a_nest_take: assert property (p_nest_take) else $error("nest level not captured");

property p_vab_field;
    @(posedge core_clk_in) disable iff (!nrst_in)
        core_ack_in && irq_q |=> vabf_q == $past(vector_address_bus_out[7:1]);
endproperty
a_vab_field: assert property (p_vab_field) else $error("vector field not captured");

property p_rst_vec;
    @(posedge core_clk_in) disable iff (!nrst_in)
        $rose(hold_q == IPC_HOLD1) |-> vector_address_bus_out == rst_a;
endproperty
a_rst_vec: assert property (p_rst_vec) else $error("reset vector dropped early");

property p_pend2_read;
    @(posedge core_clk_in) disable iff (!nrst_in)
        avs_read_in && wait_q && a == `IPC_IDX_PEND2
        |=> !avs_waitrequest_out && avs_readdata_out[15:0] == ~$past(pend_q[48:33]);
endproperty
a_pend2_read: assert property (p_pend2_read) else $error("pending 33-48 read wrong");

property p_pend0_rsvd;
    @(posedge core_clk_in) disable iff (!nrst_in)
        !avs_waitrequest_out && $past(a) == `IPC_IDX_PEND0 |-> avs_readdata_out[0];
endproperty
a_pend0_rsvd: assert property (p_pend0_rsvd) else $error("pending reserved bit low");

property p_fvh1_width;
    @(posedge core_clk_in) disable iff (!nrst_in)
        !avs_waitrequest_out && $past(a) == `IPC_IDX_FVH1 |-> avs_readdata_out[31:5] == 27'h0;
endproperty
a_fvh1_width: assert property (p_fvh1_width) else $error("fast high upper bits set");

property p_fast_win;
    @(posedge core_clk_in) disable iff (!nrst_in)
        hold_q == IPC_RUN && wcode == 2'h3 && f0_hit |=> vector_address_bus_out == $past(f0_a);
endproperty
a_fast_win: assert property (p_fast_win) else $error("fast 0 vector not used");

property p_fast1_win;
    @(posedge core_clk_in) disable iff (!nrst_in)
        hold_q == IPC_RUN && wcode == 2'h3 && f1_hit && !f0_hit |=> vector_address_bus_out == $past(f1_a);
endproperty
a_fast1_win: assert property (p_fast1_win) else $error("fast 1 vector not used");

property p_vab_norm;
    @(posedge core_clk_in) disable iff (!nrst_in)
        hold_q != IPC_HOLD0 && wcode != 2'h3 |=> vector_address_bus_out == $past(norm_a);
endproperty
a_vab_norm: assert property (p_vab_norm) else $error("normal vector not built from base");

property p_hold_quiet;
    @(posedge core_clk_in) disable iff (!nrst_in)
        hold_q != IPC_RUN |=> !core_irq_out;
endproperty
a_hold_quiet: assert property (p_hold_quiet) else $error("core request during reset hold");

property p_admit;
    @(posedge core_clk_in) disable iff (!nrst_in)
        hold_q == IPC_RUN && !dis_q && wcode > required_nest_level_q |=> core_irq_out;
endproperty
a_admit: assert property (p_admit) else $error("admissible request not sent");

property p_refuse;
    @(posedge core_clk_in) disable iff (!nrst_in)
        wcode <= required_nest_level_q |=> !core_irq_out;
endproperty
a_refuse: assert property (p_refuse) else $error("request below nest level sent");

property p_exit_clear;
    @(posedge core_clk_in) disable iff (!nrst_in)
        core_exit_in && !(core_ack_in && irq_q) |=> required_nest_level_out == 2'h0;
endproperty
a_exit_clear: assert property (p_exit_clear) else $error("nest level kept after exit");

property p_dis_write;
    @(posedge core_clk_in) disable iff (!nrst_in)
        wr && a == `IPC_IDX_CTRL && be[0] |=> dis_q == $past(wd[`IPC_CTRL_DIS]);
endproperty
a_dis_write: assert property (p_dis_write) else $error("global block bit not written");

property p_ctrl_fixed;
    @(posedge core_clk_in) disable iff (!nrst_in)
        !avs_waitrequest_out && $past(a) == `IPC_IDX_CTRL |-> avs_readdata_out[4:0] == `IPC_CTRL_FIXED;
endproperty
a_ctrl_fixed: assert property (p_ctrl_fixed) else $error("control fixed bits wrong");

endmodule
`default_nettype wire

// file: design/ipc_defines.svh
`ifndef IPC_DEFINES_SVH
`define IPC_DEFINES_SVH

// Register indexes; byte address is four times the index
`define IPC_IDX_VBASE   5'h07
`define IPC_IDX_FM0     5'h08
`define IPC_IDX_FVL0    5'h09
`define IPC_IDX_FVH0    5'h0a
`define IPC_IDX_FM1     5'h0b
`define IPC_IDX_FVL1    5'h0c
`define IPC_IDX_FVH1    5'h0d
`define IPC_IDX_PEND0   5'h0e
`define IPC_IDX_PEND1   5'h0f
`define IPC_IDX_PEND2   5'h10
`define IPC_IDX_PEND3   5'h11
`define IPC_IDX_CTRL    5'h16

// Write masks, which also fix the readable width
`define IPC_MSK_VBASE   16'h3fff
`define IPC_MSK_FM      16'h003f
`define IPC_MSK_FVL     16'hffff
`define IPC_MSK_FVH     16'h001f

// Reset values
`define IPC_RST_VBASE   16'h0080
`define IPC_RST_ZERO    16'h0000
`define IPC_RST_PEND    16'hffff
`define IPC_RST_CTRL    16'h001c

// Control register fields
`define IPC_CTRL_INT    15
`define IPC_CTRL_DIS    5
`define IPC_CTRL_FIXED  5'h1c
`define IPC_PEND0_RSVD  1'b1
`endif

// file: design/ipc_pkg.sv
package ipc_pkg;
    typedef enum logic [1:0] {
        IPC_HOLD0 = 2'b00,
        IPC_HOLD1 = 2'b01,
        IPC_RUN   = 2'b10
    } ipc_hold_t;

    // 0 = disabled, 1..3 = priority level 0..2
    typedef logic [1:0] ipc_code_t;
endpackage

// file: bench/ipc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Core side: takes a request after dly_in
// ----------------------------------------
module ipc_core_model (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       irq_in,
    input  wire logic       en_in,
    input  wire logic [1:0] dly_in,
    input  wire logic       exit_req_in,
    output logic            ack_out,
    output logic            exit_out
);
    int cnt_q;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= 0;
            ack_out <= 1'b0;
            exit_out <= 1'b0;
        end else begin
            exit_out <= exit_req_in;
            ack_out <= 1'b0;
            if (cnt_q < 0) begin
                // Dead time so the new nest level lands before another entry
                cnt_q <= cnt_q + 1;
            end else if (en_in && irq_in) begin
                ack_out <= (cnt_q == int'(dly_in));
                cnt_q <= (cnt_q == int'(dly_in)) ? -3 : cnt_q + 1;
            end else begin
                cnt_q <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/interrupt_pending_and_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module interrupt_pending_and_control_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [63:2] req = '0;
    logic [127:0] lvl = '0;
    logic cen = 1'b0;
    logic xreq = 1'b0;
    logic [1:0] dly = 2'h0;
    logic [31:0] rdat;
    logic wreq, ack, ext, irq;
    logic [1:0] nest;
    logic [20:0] vector_address_bus;
    logic [15:0] q, h, l;
    int errors = 0;
    int n_checks = 0;
    ipc_ctrl i_dut (.core_clk_in(clk), .nrst_in(nrst), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'h3),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .irq_req_in(req), .irq_level_in(lvl),
        .core_ack_in(ack), .core_exit_in(ext), .core_irq_out(irq),
        .required_nest_level_out(nest), .vector_address_bus_out(vector_address_bus));
    ipc_core_model i_core (.clk_in(clk), .nrst_in(nrst), .irq_in(irq), .en_in(cen), .dly_in(dly),
        .exit_req_in(xreq), .ack_out(ack), .exit_out(ext));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial forever #2.5 clk = ~clk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request stands until the rising edge that finds waitrequest low; data is taken there
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wdat <= {16'h0000, d};
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat[15:0];
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_nest(input logic [1:0] e);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (nest !== e && n < 32);
        chk("nest", e, nest);
        @(posedge clk);
    endtask
    task automatic set_req(input int v, input logic [1:0] c);
        req[v] <= 1'b1;
        lvl[2*v +: 2] <= c;
    endtask
    // Bit m of the joined image stands for vector m+1, active low
    function automatic logic [15:0] pend_exp(input int k, input logic [63:2] r);
        logic [63:0] x;
        x = {1'b1, ~r, 1'b1};
        return x[16*k +: 16];
    endfunction
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        void'($urandom(28331));
        set_req(40, 2'b01);
        repeat (20) @(posedge clk);
        chk("vab", 21'h004000, vector_address_bus);
        nrst <= 1'b1;
        @(negedge clk);
        @(negedge clk);
        chk("vab", 21'h004000, vector_address_bus);
        @(negedge clk);
        chk("vab", 21'h00_4050, vector_address_bus);
        // Request to the core follows one edge after the vector starts tracking
        @(negedge clk);
        chk("irq", 1'b1, irq);
        @(posedge clk);
        bus(0, 5'h16, 0); chk("ctrl", 16'h801c, q);
        bus(0, 5'h0d, 0); chk("fvh1", 16'h0000, q);
        bus(0, 5'h10, 0); chk("pend2", pend_exp(2, req), q);
        $display("test reset done");
        dly <= 2'($urandom_range(3, 0));
        cen <= 1'b1;
        wait_nest(2'b01);
        bus(0, 5'h16, 0); chk("ctrl", {1'b0, 2'b01, 7'd40, 1'b0, 5'h1c}, q);
        set_req(20, 2'b01);
        repeat (4) @(negedge clk);
        chk("irq", 1'b0, irq);
        chk("nest", 2'b01, nest);
        @(posedge clk);
        set_req(50, 2'b11);
        wait_nest(2'b11);
        bus(0, 5'h16, 0); chk("ctrl", {1'b0, 2'b11, 7'd50, 1'b0, 5'h1c}, q);
        req <= '0;
        xreq <= 1'b1;
        @(posedge clk);
        xreq <= 1'b0;
        wait_nest(2'b00);
        $display("test nesting done");
        cen <= 1'b0;
        h = 16'($urandom);
        l = 16'($urandom);
        bus(1, 5'h0d, h);
        bus(0, 5'h0d, 0); chk("fvh1", {11'h000, h[4:0]}, q);
        bus(1, 5'h0c, l);
        bus(1, 5'h0b, 16'd33);
        bus(1, 5'h0a, ~h);
        bus(1, 5'h09, ~l);
        bus(1, 5'h08, 16'd60);
        set_req(5, 2'b11);
        set_req(33, 2'b11);
        repeat (3) @(negedge clk);
        chk("vab", {h[4:0], l}, vector_address_bus);
        @(posedge clk);
        set_req(60, 2'b11);
        repeat (3) @(negedge clk);
        chk("vab", {~h[4:0], ~l}, vector_address_bus);
        @(posedge clk);
        cen <= 1'b1;
        wait_nest(2'b11);
        bus(0, 5'h16, 0); chk("field", 7'(~l[7:1]), q[12:6]);
        cen <= 1'b0;
        req <= '0;
        xreq <= 1'b1;
        @(posedge clk);
        xreq <= 1'b0;
        wait_nest(2'b00);
        $display("test fast done");
        bus(1, 5'h16, 16'h003c);
        for (int i = 0; i < 6; i++) begin
            req <= (i == 0) ? '1 : (i == 1) ? '0 : 62'({$urandom, $urandom});
            // Fast vectors stay at level 2 whatever the draw
            lvl <= {4{$urandom}} | (128'h3 << 66) | (128'h3 << 120);
            bus(1, 5'h10, 16'h0000);
            chk("irq", 1'b0, irq);
            for (int k = 0; k < 4; k++) begin
                bus(0, 5'(14 + k), 0);
                chk("pending", pend_exp(k, req), q);
            end
        end
        bus(0, 5'h1f, 0); chk("unmapped", 16'h0000, q);
        set_req(2, 2'b01);
        bus(1, 5'h16, 16'h001c);
        repeat (3) @(negedge clk);
        chk("irq", 1'b1, irq);
        $display("test pending done");
        close_out();
    end
endmodule
`default_nettype wire
